//--- flash_host_pkg.sv
`default_nettype none
package flash_host_pkg;
  // --------------------------------------------------------------------------
  // pin widths
  // --------------------------------------------------------------------------
  localparam int ADDR_W = 20;
  localparam int DATA_W = 8;
  localparam int SECTOR_BITS = 4;             // top address bits pick a 64 KB sector
  localparam int SECTOR_LSB = ADDR_W - SECTOR_BITS;

  // --------------------------------------------------------------------------
  // timing in ns and derived cycle counts at 100 MHz
  // --------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int SELECT_ACCESS_TIME_NS = 150;             // slowest speed grade
  localparam int MIN_RESET_PULSE_WIDTH_NS = 500;
  localparam int RESET_RELEASE_TO_READ_DELAY_NS = 50;
  localparam int WRITE_PULSE_NS = 50;
  localparam int WRITE_HIGH_NS = 20;
  localparam int SELECT_ACCESS_CYC = (SELECT_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_PULSE_CYC = (MIN_RESET_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_RECOVER_CYC = (RESET_RELEASE_TO_READ_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_HIGH_CYC = (WRITE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;
  localparam int SYNC_STAGES = 2;             // two-flop pin synchroniser delay

  // --------------------------------------------------------------------------
  // sequencer states
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_READ, ST_WRITE, ST_WRITE_HOLD, ST_RESET, ST_RECOVER
  } host_state_t;
endpackage
`default_nettype wire

//--- cycle_timer_if.sv
`timescale 1ns/1ns
`default_nettype none
// load/expire pair between the sequencer and its delay counter
interface cycle_timer_if;
  import flash_host_pkg::*;
  logic             load;
  logic [CNT_W-1:0] count;
  logic             done;
  modport ctrl  (output load, output count, input done);
  modport timer (input load, input count, output done);
endinterface
`default_nettype wire

//--- cycle_timer.sv
`timescale 1ns/1ns
`default_nettype none
module cycle_timer
  import flash_host_pkg::*;
(
  // clock and reset
  input  wire logic  clk,
  input  wire logic  arst_n,
  // control
  cycle_timer_if.timer tmr
);
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;

  // --------------------------------------------------------------------------
  // down counter, done when it reaches zero
  // --------------------------------------------------------------------------
  always_comb begin
    if (tmr.load) begin
      cnt_next = tmr.count;
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - 8'h01;
    end else begin
      cnt_next = cnt_reg;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // done must not look at load: the sequencer reloads on done, which would loop
  assign tmr.done = (cnt_reg == '0);
endmodule
`default_nettype wire

//--- flash_host.sv
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - read: select and output enable low, reset high
// - write strobe stays high during reads
// - write: strobe and select low, output enable high
// - wait select access time after standby
// - hold reset low minimum pulse width
// - return to idle after reset; an interrupted operation is not restarted
// - wait reset-to-read delay before reading
module flash_host
  import flash_host_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              arst_n,
  // user request
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire logic              req_write,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  input  wire logic              reset_req,
  // user answer
  output logic                   rsp_valid,
  output logic [DATA_W-1:0]      rsp_rdata,
  output logic                   dev_busy,
  output logic [SECTOR_BITS-1:0] rsp_sector,
  // flash pins
  output logic                   chip_sel_n,
  output logic                   out_en_n,
  output logic                   wr_en_n,
  output logic                   reset_n,
  output logic [ADDR_W-1:0]      addr_in,
  input  wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0]      data_out,
  output logic                   data_oe,
  input  wire logic              ready_busy_n
);
  host_state_t       state_reg, state_next;
  logic              ce_reg, ce_next;
  logic              oe_reg, oe_next;
  logic              we_reg, we_next;
  logic              rst_reg, rst_next;
  logic              doe_reg, doe_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [DATA_W-1:0] wd_reg, wd_next;
  logic [DATA_W-1:0] rd_reg, rd_next;
  logic              rv_reg, rv_next;
  logic [DATA_W-1:0] dq_s1_reg, dq_s2_reg;
  logic              rb_s1_reg, rb_s2_reg;
  cycle_timer_if     tmr ();

  cycle_timer u_timer (
    .clk    (clk),
    .arst_n (arst_n),
    .tmr    (tmr)
  );

  // --------------------------------------------------------------------------
  // pin synchronisers; data path sampled only after access time has elapsed
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dq_s1_reg <= '0;
      dq_s2_reg <= '0;
      rb_s1_reg <= 1'b1;
      rb_s2_reg <= 1'b1;
    end else begin
      dq_s1_reg <= data_in;
      dq_s2_reg <= dq_s1_reg;
      rb_s1_reg <= ready_busy_n;
      rb_s2_reg <= rb_s1_reg;
    end
  end

  // --------------------------------------------------------------------------
  // bus sequencer: one request at a time, pins from flops
  // --------------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    ce_next    = ce_reg;
    oe_next    = oe_reg;
    we_next    = we_reg;
    rst_next   = rst_reg;
    doe_next   = doe_reg;
    addr_next  = addr_reg;
    wd_next    = wd_reg;
    rd_next    = rd_reg;
    rv_next    = 1'b0;
    tmr.load   = 1'b0;
    tmr.count  = '0;
    case (state_reg)
      ST_IDLE: begin
        ce_next  = 1'b1;  // deselected between cycles is standby
        oe_next  = 1'b1;
        we_next  = 1'b1;
        doe_next = 1'b0;
        if (reset_req) begin
          rst_next   = 1'b0;
          tmr.load   = 1'b1;
          tmr.count  = CNT_W'(RESET_PULSE_CYC);
          state_next = ST_RESET;
        end else if (req_valid) begin
          addr_next = req_addr;
          ce_next   = 1'b0;
          tmr.load  = 1'b1;
          if (req_write) begin
            wd_next    = req_wdata;  // commands go out as plain bus writes
            we_next    = 1'b0;
            doe_next   = 1'b1;  // host drives only with output enable high
            tmr.count  = CNT_W'(WRITE_PULSE_CYC);
            state_next = ST_WRITE;
          end else begin
            oe_next    = 1'b0;  // write strobe left high
            tmr.count  = CNT_W'(SELECT_ACCESS_CYC + SYNC_STAGES);  // plus sync stages
            state_next = ST_READ;  // plain read, no command needed first
          end
        end
      end
      ST_READ: begin
        if (tmr.done) begin
          rd_next    = dq_s2_reg;  // array, id or status byte
          rv_next    = 1'b1;
          ce_next    = 1'b1;
          oe_next    = 1'b1;
          state_next = ST_IDLE;
        end
      end
      ST_WRITE: begin
        if (tmr.done) begin
          we_next    = 1'b1;  // strobe rises first, latching addr/data
          tmr.load   = 1'b1;
          tmr.count  = CNT_W'(WRITE_HIGH_CYC);
          state_next = ST_WRITE_HOLD;
        end
      end
      ST_WRITE_HOLD: begin
        ce_next = 1'b1;  // deselect is safe while busy
        if (tmr.done) begin
          doe_next   = 1'b0;
          rv_next    = 1'b1;
          state_next = ST_IDLE;
        end
      end
      ST_RESET: begin
        if (tmr.done && !reset_req) begin
          rst_next   = 1'b1;
          tmr.load   = 1'b1;
          tmr.count  = CNT_W'(RESET_RECOVER_CYC);
          state_next = ST_RECOVER;
        end
      end
      ST_RECOVER: begin
        // hold off until internal reset finishes and busy clears
        if (tmr.done && rb_s2_reg) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_IDLE;
      ce_reg    <= 1'b1;
      oe_reg    <= 1'b1;
      we_reg    <= 1'b1;
      rst_reg   <= 1'b1;
      doe_reg   <= 1'b0;
      addr_reg  <= '0;
      wd_reg    <= '0;
      rd_reg    <= '0;
      rv_reg    <= 1'b0;
    end else begin
      state_reg <= state_next;
      ce_reg    <= ce_next;
      oe_reg    <= oe_next;
      we_reg    <= we_next;
      rst_reg   <= rst_next;
      doe_reg   <= doe_next;
      addr_reg  <= addr_next;
      wd_reg    <= wd_next;
      rd_reg    <= rd_next;
      rv_reg    <= rv_next;
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign req_ready  = (state_reg == ST_IDLE) && !reset_req;
  assign rsp_valid  = rv_reg;
  assign rsp_rdata  = rd_reg;
  assign dev_busy   = !rb_s2_reg;
  assign rsp_sector = addr_reg[ADDR_W-1:SECTOR_LSB];
  assign chip_sel_n = ce_reg;
  assign out_en_n   = oe_reg;
  assign wr_en_n    = we_reg;
  assign reset_n    = rst_reg;
  assign addr_in    = addr_reg;
  assign data_out   = wd_reg;
  assign data_oe    = doe_reg;  // never while output enable low
endmodule
`default_nettype wire

//--- flash_host_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module flash_host_monitor
  import flash_host_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // request side
  input  wire logic req_valid,
  input  wire logic req_ready,
  input  wire logic req_write,
  input  wire logic rsp_valid,
  // flash pins
  input  wire logic chip_sel_n,
  input  wire logic out_en_n,
  input  wire logic wr_en_n,
  input  wire logic reset_n,
  input  wire logic data_oe
);
  int oe_cnt;
  int wr_cnt;
  int rst_cnt;
  // low-time counters: width rules are lengths, not edges
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      oe_cnt <= 0;
      wr_cnt <= 0;
      rst_cnt <= 0;
    end else begin
      oe_cnt <= out_en_n ? 0 : oe_cnt + 1;
      wr_cnt <= wr_en_n ? 0 : wr_cnt + 1;
      rst_cnt <= reset_n ? 0 : rst_cnt + 1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  chk_read_pins: assert property (!out_en_n |-> !chip_sel_n && wr_en_n && reset_n && !data_oe)
    else $error("read strobes wrong");
  chk_write_pins: assert property (!wr_en_n |-> !chip_sel_n && out_en_n && data_oe && reset_n)
    else $error("write strobes wrong");
  chk_access_wait: assert property ($rose(out_en_n) |-> oe_cnt >= SELECT_ACCESS_CYC)
    else $error("read ended too soon");
  chk_write_pulse: assert property ($rose(wr_en_n) |-> wr_cnt >= WRITE_PULSE_CYC && !chip_sel_n)
    else $error("write pulse bad");
  chk_reset_width: assert property ($rose(reset_n) |-> rst_cnt >= RESET_PULSE_CYC)
    else $error("reset pulse short");
  chk_reset_recover: assert property ($rose(reset_n) |-> (out_en_n && wr_en_n)[*5])
    else $error("access too soon after reset");
  chk_reset_quiet: assert property (!reset_n |-> chip_sel_n && out_en_n && wr_en_n && !data_oe)
    else $error("access during reset");
  // take edge, 17 timer cycles, one capture edge, pulse seen one edge later
  chk_read_lat: assert property (req_valid && req_ready && !req_write |-> ##19 rsp_valid)
    else $error("read answer late");
  chk_write_lat: assert property (req_valid && req_ready && req_write |-> ##10 rsp_valid)
    else $error("write answer late");
  cover property (req_valid && req_ready && req_write);
  cover property (req_valid && req_ready && !req_write);
  cover property ($rose(reset_n));
endmodule
bind flash_host flash_host_monitor u_mon (.clk, .arst_n, .req_valid, .req_ready, .req_write, .rsp_valid,
  .chip_sel_n, .out_en_n, .wr_en_n, .reset_n, .data_oe);
`default_nettype wire

//--- flash_dev_model.sv
`timescale 1ns/1ns
`default_nettype none
module flash_dev_model
  import flash_host_pkg::*;
#(
  parameter logic [7:0] ID_CODE = 8'h5a, // arbitrary value
  parameter int         ACC_NS  = 140,
  parameter int         RST_NS  = 1000
)
(
  // flash pins, 20 address and 8 data lines
  input  wire logic              chip_sel_n,
  input  wire logic              out_en_n,
  input  wire logic              wr_en_n,
  input  wire logic              reset_n,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [DATA_W-1:0] data_out,
  output logic      [DATA_W-1:0] data_in,
  output logic                   ready_busy_n
);
  logic [7:0] mem [int];
  int  mode = 0;
  int  busy_t = 0;
  time sel_t = 0;
  function automatic logic [7:0] rdval(input logic [ADDR_W-1:0] a);
    return mem.exists(int'(a)) ? mem[int'(a)] : a[7:0] ^ a[19:12];
  endfunction
  initial data_in = 8'h00;
  // command latch, separate from the array, taken at the first strobe to rise
  always @(posedge wr_en_n or posedge chip_sel_n) begin
    if (reset_n && out_en_n && (wr_en_n ^ chip_sel_n) && busy_t == 0) begin
      case (data_out)
        8'h90: mode = 1;
        8'hf0: mode = 0;
        8'h30: busy_t = 2000;
        default: mem[int'(addr_in)] = data_out;
      endcase
    end
  end
  // 1 ns steps; a released bus toggles so a stale byte never looks valid
  always #1 begin
    if (!reset_n) begin
      mode = 0;
      if (busy_t > RST_NS) busy_t = RST_NS;
    end
    if (busy_t > 0) busy_t = busy_t - 1;
    if (chip_sel_n || !reset_n) sel_t = $time;
    ready_busy_n <= (busy_t == 0);
    if (!chip_sel_n && !out_en_n && reset_n && $time - sel_t >= ACC_NS)
      data_in <= busy_t > 0 ? 8'h48 : mode != 0 ? ID_CODE : rdval(addr_in);
    else
      data_in <= ~data_in;
  end
endmodule
`default_nettype wire

//--- test_flash_host_decode.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, s) begin checks++; if ((s) !== (e)) begin bad_count++; $display("Error %s exp %h got %h", nm, e, s); end end
module test_flash_host;
  import flash_host_pkg::*;
  typedef struct packed {logic w; logic [19:0] a; logic [7:0] d; logic [7:0] e;} row_t;
  logic clk = 1'b0, arst_n, req_valid, req_write, reset_req, rsp_valid, dev_busy, req_ready;
  logic chip_sel_n, out_en_n, wr_en_n, reset_n, data_oe, ready_busy_n;
  logic [ADDR_W-1:0] req_addr, addr_in;
  logic [DATA_W-1:0] req_wdata, rsp_rdata, data_in, data_out, rd;
  logic [SECTOR_BITS-1:0] rsp_sector;
  int checks = 0, bad_count = 0;
  row_t rows [10] = '{'{0, 20'h00123, 0, 8'h23}, '{1, 20'h00123, 8'ha5, 0}, '{0, 20'h00123, 0, 8'ha5},
    '{0, 20'hf0f00, 0, 8'hf0}, '{1, 20'hfffff, 8'h3c, 0}, '{0, 20'hfffff, 0, 8'h3c}, '{1, 20'h00555, 8'h90, 0},
    '{0, 20'h00000, 0, 8'h5a}, '{1, 20'h00000, 8'hf0, 0}, '{0, 20'h00123, 0, 8'ha5}};
  always #5 clk = ~clk;
  flash_host dut (.clk, .arst_n, .req_valid, .req_ready, .req_write, .req_addr, .req_wdata, .reset_req,
    .rsp_valid, .rsp_rdata, .dev_busy, .rsp_sector, .chip_sel_n, .out_en_n, .wr_en_n, .reset_n,
    .addr_in, .data_in, .data_out, .data_oe, .ready_busy_n);
  flash_dev_model #(.ID_CODE(8'h5a)) u_dev (.chip_sel_n, .out_en_n, .wr_en_n, .reset_n, .addr_in,
    .data_out, .data_in, .ready_busy_n);
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // bounded wait at the falling edge, where outputs have settled
  task automatic wait_for(input bit rsp);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while ((rsp ? rsp_valid : req_ready) !== 1'b1 && n < 500);
    // judge by the awaited signal, so a hit on the last try still counts as a hit
    if ((rsp ? rsp_valid : req_ready) !== 1'b1) begin
      bad_count++;
      wrap_up;
    end
  endtask
  // one request held until taken, then the single answer pulse
  task automatic op(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    wait_for(0);
    @(posedge clk);
    req_valid <= 1'b0;
    wait_for(1);
    rd = rsp_rdata;
    @(posedge clk);
  endtask
  initial begin
    arst_n = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = '0;
    req_wdata = '0;
    reset_req = 1'b0;
    repeat (16) @(posedge clk);
    `CHK("pins idle", 4'hf, {chip_sel_n, out_en_n, wr_en_n, reset_n})
    `CHK("oe idle", 1'b0, data_oe)
    arst_n <= 1'b1;
    @(posedge clk);
    foreach (rows[i]) begin
      op(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) `CHK("read", rows[i].e, rd)
      `CHK("sector", rows[i].a[19:16], rsp_sector)
    end
    // erase left running while deselected, then reset across it
    op(1'b1, 20'h10000, 8'h30);
    repeat (10) @(posedge clk);
    `CHK("busy", 1'b1, dev_busy)
    op(1'b0, 20'h10000, 8'h00);
    `CHK("status", 8'h48, rd)
    reset_req <= 1'b1;
    repeat (60) @(posedge clk);
    `CHK("reset pin", 1'b0, reset_n)
    `CHK("refused", 1'b0, req_ready)
    reset_req <= 1'b0;
    wait_for(0);
    `CHK("ready after reset", 1'b1, ready_busy_n)
    `CHK("busy cleared", 1'b0, dev_busy)
    @(posedge clk);
    op(1'b0, 20'h00123, 8'h00);
    `CHK("array after reset", 8'ha5, rd)
    op(1'b1, 20'h10000, 8'h30);
    repeat (4) @(posedge clk);
    `CHK("busy again", 1'b1, dev_busy)
    wrap_up;
  end
endmodule
`default_nettype wire
